//--- core/hdcfg_device_config.sv
// Hub device configuration register with strap capture and power-control steering
`timescale 1ns/1ps
module hdcfg_device_config #(
	parameter int NUM_PORTS = hdcfg_pkg::NUM_PORTS
) (
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 eeprom_mode,
	input  wire logic                 load_strobe,
	input  wire logic [7:0]           load_addr,
	input  wire logic [7:0]           load_data,
	input  wire logic                 read_strobe,
	input  wire logic [7:0]           read_addr,
	output logic      [7:0]           read_data,
	input  wire logic                 gang_strap_pin,
	input  wire logic                 power_report_strap_pin,
	input  wire logic [NUM_PORTS-1:0] port_power_request,
	output logic      [NUM_PORTS-1:0] port_power_enable_pins,
	input  wire logic                 force_accept_seen,
	input  wire logic                 upstream_disconnect,
	output logic                      u1u2_allowed,
	output logic                      string_regs_write_enable,
	output logic                      serial_regs_write_enable,
	output logic                      power_status_report_on,
	output logic                      straps_valid
);
	// ****************************************
	// Strap synchronisers
	// ****************************************
	// Straps come from pins, so they pass two flops before capture
	// No reset here: the flops fill while reset is held, so the clock must
	// run for one cycle before release or the capture sees stale straps
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;

	always_ff @(posedge clk_sys) begin
		strap_meta <= {gang_strap_pin, power_report_strap_pin};
		strap_sync <= strap_meta;
	end

	// ****************************************
	// Capture sequencer
	// ****************************************
	// One settle cycle after release; a load in the capture cycle still wins
	hdcfg_pkg::hdcfg_strap_state_t state;
	hdcfg_pkg::hdcfg_strap_state_t next_state;
	logic                          capture;

	always_comb begin
		case (state)
			hdcfg_pkg::HDCFG_IN_RESET: next_state = hdcfg_pkg::HDCFG_SETTLE;
			hdcfg_pkg::HDCFG_SETTLE:   next_state = hdcfg_pkg::HDCFG_RUN;
			hdcfg_pkg::HDCFG_RUN:      next_state = hdcfg_pkg::HDCFG_RUN;
			default:                   next_state = hdcfg_pkg::HDCFG_IN_RESET;
		endcase
	end

	assign capture      = (state == hdcfg_pkg::HDCFG_SETTLE);
	assign straps_valid = (state == hdcfg_pkg::HDCFG_RUN);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= hdcfg_pkg::HDCFG_IN_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Register storage
	// ****************************************
	// Writable bits only; bits 4 and 0 are constants with no storage
	logic string_we;
	logic serial_we;
	logic link_low_power_off;
	logic ganged;
	logic power_status_report_off;
	logic rsvd_rw;
	logic hit_write;
	logic hit_read;
	logic [7:0] reg_value;

	assign hit_write = load_strobe && (load_addr == hdcfg_pkg::DEVICE_CONFIGURATION_OFFSET);
	assign hit_read  = read_strobe && (read_addr == hdcfg_pkg::DEVICE_CONFIGURATION_OFFSET);

	// A load arriving in the capture cycle is taken over the strap value
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			string_we               <= hdcfg_pkg::STRING_WE_RESET;
			serial_we               <= hdcfg_pkg::SERIAL_WE_RESET;
			link_low_power_off      <= hdcfg_pkg::LINK_LP_OFF_RESET;
			ganged                  <= 1'b0;
			power_status_report_off <= 1'b0;
			rsvd_rw                 <= hdcfg_pkg::RSVD_RW_RESET;
		end else if (hit_write) begin
			// Same path for EEPROM load and SMBus write
			string_we               <= load_data[hdcfg_pkg::STRING_WE_BIT];
			serial_we               <= load_data[hdcfg_pkg::SERIAL_WE_BIT];
			link_low_power_off      <= load_data[hdcfg_pkg::LINK_LP_OFF_BIT];
			ganged                  <= load_data[hdcfg_pkg::GANGED_BIT];
			power_status_report_off <= load_data[hdcfg_pkg::PWR_REPORT_OFF_BIT];
			rsvd_rw                 <= load_data[hdcfg_pkg::RSVD_RW_BIT];
		end else if (capture) begin
			ganged                  <= strap_sync[1];
			power_status_report_off <= strap_sync[0];
		end
	end

	always_comb begin
		reg_value                                  = 8'h00;
		reg_value[hdcfg_pkg::STRING_WE_BIT]        = string_we;
		reg_value[hdcfg_pkg::SERIAL_WE_BIT]        = serial_we;
		reg_value[hdcfg_pkg::LINK_LP_OFF_BIT]      = link_low_power_off;
		reg_value[hdcfg_pkg::RSVD_ONE_BIT]         = hdcfg_pkg::RSVD_ONE_VALUE;
		reg_value[hdcfg_pkg::GANGED_BIT]           = ganged;
		reg_value[hdcfg_pkg::PWR_REPORT_OFF_BIT]   = power_status_report_off;
		reg_value[hdcfg_pkg::RSVD_RW_BIT]          = rsvd_rw;
		reg_value[hdcfg_pkg::RSVD_ZERO_BIT]        = hdcfg_pkg::RSVD_ZERO_VALUE;
	end

	// Read data is registered; unmapped offsets read as zero
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			read_data <= 8'h00;
		end else if (read_strobe) begin
			read_data <= hit_read ? reg_value : 8'h00;
		end
	end

	// ****************************************
	// Steering outputs
	// ****************************************
	logic [NUM_PORTS-1:0] next_power;

	assign string_regs_write_enable = string_we;
	assign serial_regs_write_enable = serial_we;
	assign power_status_report_on   = !power_status_report_off;

	// Ganged mode with power status reporting on drives only the first pin, from any port's request
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			if (gi == 0) begin : g_first
				assign next_power[gi] = (power_status_report_on && ganged) ?
					|port_power_request : port_power_request[gi];
			end else begin : g_rest
				assign next_power[gi] = (power_status_report_on && ganged) ?
					1'b0 : port_power_request[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			port_power_enable_pins <= '0;
		end else begin
			port_power_enable_pins <= next_power;
		end
	end

	hdcfg_lpm_gate u_lpm_gate (
		.clk_sys             (clk_sys),
		.resetn              (resetn),
		.link_low_power_off  (link_low_power_off),
		.force_accept_seen   (force_accept_seen),
		.upstream_disconnect (upstream_disconnect),
		.u1u2_allowed        (u1u2_allowed)
	);

	// ****************************************
	// Checks
	// ****************************************
	sequence s_cfg_read;
		hit_read;
	endsequence

	rsvd_fixed_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_cfg_read |=> (read_data[4] == 1'b1 && read_data[0] == 1'b0))
		else $error("Reserved bits read wrong");
	reg_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_cfg_read |=> (read_data == $past(reg_value)))
		else $error("Read data differs from register");
	foreign_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(load_strobe && !hit_write && !capture) |=> (reg_value == $past(reg_value)))
		else $error("Write to another offset changed register");
	string_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(hit_write && !load_data[7]) |=> !string_regs_write_enable)
		else $error("String gate did not clear");
	serial_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(hit_write && load_data[6]) |=> serial_regs_write_enable)
		else $error("Serial gate did not set");
	gang_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(capture && !hit_write) |=> (ganged == $past(strap_sync[1])))
		else $error("Gang strap not captured");
	report_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(capture && !hit_write) |=> (power_status_report_on == !$past(strap_sync[0])))
		else $error("Report strap not captured");
	ganged_pins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(power_status_report_on && ganged) |=> (port_power_enable_pins[NUM_PORTS-1:1] == '0))
		else $error("Ganged mode drove extra pins");
	single_pins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!ganged) |=> (port_power_enable_pins == $past(port_power_request)))
		else $error("Per-port power not followed");
	lp_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(hit_write && load_data[5] && !force_accept_seen) ##1 (!u_lpm_gate.forced)
		|-> !u1u2_allowed)
		else $error("Loaded low-power disable not honoured");
endmodule

//--- core/hdcfg_lpm_gate.sv
// Link low-power permission gate with sticky force-accept latch
`timescale 1ns/1ps
module hdcfg_lpm_gate (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic link_low_power_off,
	input  wire logic force_accept_seen,
	input  wire logic upstream_disconnect,
	output logic      u1u2_allowed
);
	// ****************************************
	// Force accept latch
	// ****************************************
	// Latch stays set until power-on reset or upstream disconnect
	logic forced;
	logic next_forced;

	assign next_forced  = upstream_disconnect ? 1'b0 : (forced | force_accept_seen);
	assign u1u2_allowed = !link_low_power_off || forced;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			forced <= 1'b0;
		end else begin
			forced <= next_forced;
		end
	end

	lpm_blocked_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(link_low_power_off && !forced) |-> !u1u2_allowed)
		else $error("Low-power states allowed while disabled");
	lpm_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(force_accept_seen && !upstream_disconnect) |=> (u1u2_allowed [*2]
		or upstream_disconnect))
		else $error("Force accept did not hold low-power enable");
endmodule

//--- core/hdcfg_pkg.sv
// Package: offset, field positions and reset values of the hub device configuration register
package hdcfg_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] DEVICE_CONFIGURATION_OFFSET = 8'h05;
	localparam int         STRING_WE_BIT               = 7;
	localparam int         SERIAL_WE_BIT               = 6;
	localparam int         LINK_LP_OFF_BIT             = 5;
	localparam int         RSVD_ONE_BIT                = 4;
	localparam int         GANGED_BIT                  = 3;
	localparam int         PWR_REPORT_OFF_BIT          = 2;
	localparam int         RSVD_RW_BIT                 = 1;
	localparam int         RSVD_ZERO_BIT               = 0;
	localparam logic       STRING_WE_RESET             = 1'b0;
	localparam logic       SERIAL_WE_RESET             = 1'b0;
	localparam logic       LINK_LP_OFF_RESET           = 1'b0;
	localparam logic       RSVD_ONE_VALUE              = 1'b1;
	localparam logic       RSVD_RW_RESET               = 1'b0;
	localparam logic       RSVD_ZERO_VALUE             = 1'b0;
	localparam int         NUM_PORTS                   = 4;

	// Strap capture sequencing
	typedef enum logic [1:0] {
		HDCFG_IN_RESET = 2'b00,
		HDCFG_SETTLE   = 2'b01,
		HDCFG_RUN      = 2'b11
	} hdcfg_strap_state_t;
endpackage

//--- testbench/hdcfg_host_model.sv
// Host model: issues register loads and reads toward the configuration block
`timescale 1ns/1ps
module hdcfg_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] read_data,
	output logic            load_strobe,
	output logic [7:0]      load_addr,
	output logic [7:0]      load_data,
	output logic            read_strobe,
	output logic [7:0]      read_addr
);
	initial begin
		load_strobe = 1'b0;
		load_addr   = 8'h00;
		load_data   = 8'h00;
		read_strobe = 1'b0;
		read_addr   = 8'h00;
	end

	// Gap cycles make the host prompt or slow; one idle edge always separates strobes
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input int gap);
		repeat (gap + 1) @(negedge clk_sys);
		load_addr   = addr;
		load_data   = data & 8'hfd;
		load_strobe = 1'b1;
		@(negedge clk_sys);
		load_strobe = 1'b0;
		load_addr   = ~addr;
		load_data   = ~data;
	endtask

	task automatic read_reg(input logic [7:0] addr, input int gap, output logic [7:0] data);
		repeat (gap + 1) @(negedge clk_sys);
		read_addr   = addr;
		read_strobe = 1'b1;
		@(negedge clk_sys);
		read_strobe = 1'b0;
		read_addr   = ~addr;
		data        = read_data;
	endtask
endmodule

//--- testbench/tb_hdcfg_device_config.sv
// Self-checking bench for the hub device configuration register
`timescale 1ns/1ps
module tb_hdcfg_device_config;
	logic       clk_sys                = 1'b0;
	logic       resetn                 = 1'b0;
	logic       eeprom_mode            = 1'b0;
	logic       gang_strap_pin         = 1'b0;
	logic       power_report_strap_pin = 1'b0;
	logic [3:0] port_power_request     = 4'h0;
	logic       force_accept_seen      = 1'b0;
	logic       upstream_disconnect    = 1'b0;
	logic       load_strobe, read_strobe, u1u2_allowed, straps_valid;
	logic       string_regs_write_enable, serial_regs_write_enable, power_status_report_on;
	logic [7:0] load_addr, load_data, read_addr, read_data, got, d, a, m;
	logic [3:0] port_power_enable_pins;
	int         num_errors = 0;
	int         num_checks = 0;
	int         cycles     = 0;
	int         seed       = 43100;
	int         model_reg  = 0;
	int         latch      = 0;

	always #12.5 clk_sys = ~clk_sys;

	hdcfg_device_config #(.NUM_PORTS(4)) uut (.clk_sys(clk_sys), .resetn(resetn),
		.eeprom_mode(eeprom_mode), .load_strobe(load_strobe), .load_addr(load_addr),
		.load_data(load_data), .read_strobe(read_strobe), .read_addr(read_addr),
		.read_data(read_data), .gang_strap_pin(gang_strap_pin),
		.power_report_strap_pin(power_report_strap_pin),
		.port_power_request(port_power_request), .port_power_enable_pins(port_power_enable_pins),
		.force_accept_seen(force_accept_seen), .upstream_disconnect(upstream_disconnect),
		.u1u2_allowed(u1u2_allowed), .string_regs_write_enable(string_regs_write_enable),
		.serial_regs_write_enable(serial_regs_write_enable),
		.power_status_report_on(power_status_report_on), .straps_valid(straps_valid));

	hdcfg_host_model host (.clk_sys(clk_sys), .read_data(read_data), .load_strobe(load_strobe),
		.load_addr(load_addr), .load_data(load_data), .read_strobe(read_strobe),
		.read_addr(read_addr));

	// ****************************************
	// Compare and report
	// ****************************************
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic chk1(input string name, input logic exp, input logic seen);
		chk8(name, {7'h00, exp}, {7'h00, seen});
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard; a full run needs roughly six hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ****************************************
	// Model-driven checks
	// ****************************************
	task automatic check_outputs();
		m = model_reg[7:0];
		chk1("string_we", m[7], string_regs_write_enable);
		chk1("serial_we", m[6], serial_regs_write_enable);
		chk1("u1u2_allowed", !m[5] || latch != 0, u1u2_allowed);
		chk1("report_on", !m[2], power_status_report_on);
		host.read_reg(8'h05, 0, got);
		chk8("config_read", m, got);
		port_power_request = 4'($random(seed));
		@(negedge clk_sys);
		d = m[3] ? {7'h00, |port_power_request} : {4'h0, port_power_request};
		if (!m[2]) chk8("power_pins", d, {4'h0, port_power_enable_pins});
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data, input int gap);
		host.write_reg(addr, data, gap);
		if (addr == 8'h05) model_reg = {data[7:5], 1'b1, data[3:2], 2'h0};
		check_outputs();
	endtask

	task automatic pulse(input logic f, input logic u);
		@(negedge clk_sys);
		force_accept_seen   = f;
		upstream_disconnect = u;
		@(negedge clk_sys);
		force_accept_seen   = 1'b0;
		upstream_disconnect = 1'b0;
		latch = u ? 0 : (f ? 1 : latch);
		chk1("u1u2_allowed", !model_reg[5] || latch != 0, u1u2_allowed);
	endtask

	// Straps change only while reset is held, so they are stable through the sync flops
	task automatic do_reset(input int i);
		@(negedge clk_sys);
		resetn                 = 1'b0;
		gang_strap_pin         = 1'(i);
		power_report_strap_pin = 1'(i >> 1);
		repeat (8) @(negedge clk_sys);
		resetn = 1'b1;
		@(negedge clk_sys);
		chk1("straps_early", 1'b0, straps_valid);
		repeat (2) @(negedge clk_sys);
		model_reg = {4'h1, gang_strap_pin, power_report_strap_pin, 2'h0};
		latch     = 0;
		chk1("straps_valid", 1'b1, straps_valid);
		check_outputs();
	endtask

	initial begin
		for (int i = 0; i < 4; i++) begin
			do_reset(i);
			for (int n = 0; n < 12; n++) begin
				d           = 8'($random(seed));
				a           = (n % 3 == 2) ? 8'($random(seed)) : 8'h05;
				eeprom_mode = d[0];
				wr(a, d, n % 3);
				host.read_reg(a, 1, got);
				chk8("any_read", (a == 8'h05) ? model_reg[7:0] : 8'h00, got);
			end
			pulse(1'b0, 1'b1);
			wr(8'h05, 8'h20, 0);
			pulse(1'b1, 1'b1);
			pulse(1'b1, 1'b0);
			wr(8'h05, 8'h00, 1);
			wr(8'h05, 8'h20, 0);
			pulse(1'b0, 1'b1);
		end
		end_of_test();
	end
endmodule
